//--- rtl/acl_entry_store.sv
// One port's sixteen-entry ACL table with byte-enabled writes
`timescale 1ns/1ns
module acl_entry_store
	import acl_vlan_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   wr_i,
	input  wire logic                   rd_i,
	input  wire logic [ACL_IDX_W-1:0]   index_i,
	input  wire logic [ACL_BYTES-1:0]   byte_en_i,
	input  wire logic [8*ACL_BYTES-1:0] data_i,
	output logic      [8*ACL_BYTES-1:0] data_o,
	output logic                        rd_done_o,
	output logic                        wr_done_o
);

	// Per-byte storage; byte k is staging register k
	genvar k;
	generate
		for (k = 0; k < ACL_BYTES; k++)
		begin : g_byte
			logic [7:0] mem [ACL_ENTRIES];
			logic [7:0] rd_byte;
			// Enable bit 15-k governs byte k; byte C never stored
			wire wr_byte = wr_i & byte_en_i[ACL_BYTES-1-k] & (k != UNUSED_BYTE); // [RQ6] [RQ7] [RQ8]

			// Table write, no reset on storage
			always_ff @(posedge clk_i)
			begin
				if (wr_byte)
					mem[index_i] <= data_i[8*k +: 8];
			end

			// Registered read of the addressed entry
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					rd_byte <= BYTE_RST;
				else if (rd_i)
					rd_byte <= (k == UNUSED_BYTE) ? BYTE_RST : mem[index_i]; // [RQ11]
			end

			// One driver per output byte
			assign data_o[8*k +: 8] = rd_byte;
		end
	endgenerate

	// Completion pulses one cycle after the command
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rd_done_o <= 1'b0;
			wr_done_o <= 1'b0;
		end
		else
		begin
			rd_done_o <= rd_i;
			wr_done_o <= wr_i;
		end
	end

endmodule : acl_entry_store

//--- rtl/acl_vlan_pkg.sv
// Constants, offsets and field layouts for the ACL and VLAN indirect access block
package acl_vlan_pkg;

	// Table geometry
	localparam int NUM_PORTS    = 3;
	localparam int ACL_ENTRIES  = 16;
	localparam int ACL_BYTES    = 16;
	localparam int ACL_IDX_W    = 4;
	localparam int VLAN_IDX_W   = 12;
	localparam int VLAN_ENTRIES = 4096;
	localparam int VLAN_WORDS   = 3;
	localparam int VLAN_WORD_W  = 32;

	// Register indices; byte address is four times the index
	localparam logic [3:0]  ACL_WIN_PAGE    = 4'h6;
	localparam logic [7:0]  ACL_BSEL_HI_OFS = 8'h10;
	localparam logic [7:0]  ACL_BSEL_LO_OFS = 8'h11;
	localparam logic [7:0]  ACL_CTRL_OFS    = 8'h12;
	localparam logic [15:0] VLAN_INDEX_REG  = 16'h0100;
	localparam logic [15:0] VLAN_CTRL_REG   = 16'h0101;
	localparam logic [15:0] VLAN_ENTRY0_REG = 16'h0102;

	// Control register bit positions
	localparam int VLAN_START_BIT  = 7;
	localparam int VLAN_READ_BIT   = 0;
	localparam int ACL_DIR_BIT     = 4;
	localparam int ACL_RD_DONE_BIT = 5;
	localparam int ACL_WR_DONE_BIT = 6;

	// Staging byte layout
	localparam int UNUSED_BYTE   = 12;
	localparam int UNUSED_BE_BIT = 3;
	localparam int RULE_GROUP_HI = 14;
	localparam int RULE_GROUP_LO = 15;

	// Field positions inside staging bytes
	localparam logic [7:0] FIRST_RULE_NUMBER_M   = 8'h0f;
	localparam logic [7:0] MATCH_MODE_M          = 8'h30;
	localparam logic [7:0] MATCH_ENABLE_SELECT_M = 8'h0c;
	localparam logic [7:0] SRC_DST_SELECT_M      = 8'h02;
	localparam logic [7:0] COMPARE_SENSE_M       = 8'h01;
	localparam logic [7:0] PRIORITY_MODE_ACTION_M = 8'hc0;
	localparam logic [7:0] PRIORITY_M            = 8'h38;
	localparam logic [7:0] REMARK_ENABLE_M       = 8'h04;
	localparam logic [7:0] REMARK_VALUE_HI_M     = 8'h03;
	localparam logic [7:0] REMARK_VALUE_LO_M     = 8'h80;
	localparam logic [7:0] MAP_MODE_ACTION_M     = 8'h60;
	localparam logic [7:0] FORWARD_M             = 8'h7f;
	localparam logic [7:0] FULL_BYTE_M           = 8'hff;

	// Values after reset
	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;

endpackage : acl_vlan_pkg

//--- rtl/acl_vlan_table_indirect_access.sv
// Wishbone register bank for indirect VLAN and per-port ACL table access
// Function
// RQ1 - Software loads VLAN index before reading
// RQ2 - Start bit 7 launches VLAN op, self-clears
// RQ3 - Read result lands in three VLAN entry registers
// RQ4 - Each port owns sixteen-entry ACL table, indexed
// RQ5 - ACL registers replicated in each port's window
// RQ6 - Sixteen byte enables choose written staging bytes
// RQ7 - Enable bit 0 governs byte F, reversed
// RQ8 - Byte C unused, enable bit 3 ignored
// RQ9 - Control write with bit 4 clear reads
// RQ10 - Read status flag shows read completion
// RQ11 - Read entry loads staging bytes 0 to F
// RQ12 - Control write with bit 4 set writes
// RQ13 - Write status flag shows write completion
// RQ14 - Bytes 0 and 1 hold process, match fields
// RQ15 - Byte A holds priority and remark fields
// RQ16 - Byte B holds remark bit, map mode
// RQ17 - Rule group split over bytes E and F
// RQ18 - VLAN index is twelve-bit VLAN identifier
// RQ19 - Software waits for completion before new commands
`timescale 1ns/1ns
module acl_vlan_table_indirect_access
	import acl_vlan_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o
);

	typedef enum logic [1:0] {
		VLAN_IDLE,
		VLAN_LOOK,
		VLAN_LOAD,
		VLAN_STORE
	} vlan_state_e;

	// Reserved bits of each staging byte are held at zero
	function automatic logic [7:0] byte_mask(input int k);
		case (k)
			0:  byte_mask = FIRST_RULE_NUMBER_M; // [RQ14]
			1:  byte_mask = MATCH_MODE_M | MATCH_ENABLE_SELECT_M
				| SRC_DST_SELECT_M | COMPARE_SENSE_M; // [RQ14]
			10: byte_mask = PRIORITY_MODE_ACTION_M | PRIORITY_M
				| REMARK_ENABLE_M | REMARK_VALUE_HI_M; // [RQ15]
			11: byte_mask = REMARK_VALUE_LO_M | MAP_MODE_ACTION_M; // [RQ16]
			12: byte_mask = BYTE_RST; // [RQ8]
			13: byte_mask = FORWARD_M;
			RULE_GROUP_HI: byte_mask = FULL_BYTE_M; // [RQ17]
			RULE_GROUP_LO: byte_mask = FULL_BYTE_M; // [RQ17]
			default: byte_mask = FULL_BYTE_M;
		endcase
	endfunction : byte_mask

	// Port window decode: returns hit flag and zero-based port
	function automatic logic [2:0] port_hit(input logic [15:0] idx);
		logic [3:0] nib;
		nib = idx[15:12];
		if (idx[11:8] == ACL_WIN_PAGE && nib >= 4'h1 && nib <= 4'(NUM_PORTS))
			port_hit = {1'b1, 2'(nib - 4'h1)}; // [RQ5]
		else
			port_hit = 3'h0;
	endfunction : port_hit

	// Bus handshake: ack one cycle after request, writes at the ack edge
	logic ack_q;
	wire         req       = cyc_i & stb_i;
	wire         wr_take   = req & ack_q & we_i & sel_i[0];
	wire  [15:0] reg_idx   = adr_i[17:2];
	wire         upper_ok  = (adr_i[31:18] == 14'h0000);
	wire  [2:0]  hit       = port_hit(reg_idx);
	wire         acl_hit   = hit[2] & upper_ok;
	wire  [1:0]  hit_port  = hit[1:0];
	wire  [7:0]  sub       = reg_idx[7:0];
	wire         glob_hit  = upper_ok & (reg_idx[15:8] == VLAN_INDEX_REG[15:8]);

	// Handshake flops
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	assign ack_o = ack_q;

	// Per-port read values gathered for the read mux
	wire [7:0] acl_rd [NUM_PORTS];

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++)
		begin : g_port
			logic [7:0]           stage [ACL_BYTES];
			logic [7:0]           bsel_hi;
			logic [7:0]           bsel_lo;
			logic [ACL_IDX_W-1:0] acl_index;
			logic                 acl_dir;
			logic                 rd_done;
			logic                 wr_done;
			logic [8*ACL_BYTES-1:0] stage_flat;
			logic [8*ACL_BYTES-1:0] table_q;
			logic                 rd_fin;
			logic                 wr_fin;

			// Writes addressed to this port's window
			wire sel_port = wr_take & acl_hit & (hit_port == 2'(p));
			wire go       = sel_port & (sub == ACL_CTRL_OFS);  // [RQ9] [RQ12]
			wire go_wr    = go & dat_i[ACL_DIR_BIT];          // [RQ12]
			wire go_rd    = go & ~dat_i[ACL_DIR_BIT];         // [RQ9]

			// Flatten staging bytes toward the table
			genvar b;
			for (b = 0; b < ACL_BYTES; b++)
			begin : g_flat
				assign stage_flat[8*b +: 8] = stage[b];
			end

			// Sixteen-entry table of this port
			acl_entry_store u_store ( // [RQ4]
				.clk_i     (clk_i),
				.rst_i     (rst_i),
				.wr_i      (go_wr),
				.rd_i      (go_rd),
				.index_i   (dat_i[ACL_IDX_W-1:0]),
				.byte_en_i ({bsel_hi, bsel_lo}),
				.data_i    (stage_flat),
				.data_o    (table_q),
				.rd_done_o (rd_fin),
				.wr_done_o (wr_fin)
			);

			// Command register fields and completion flags; set beats clear
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					acl_index <= '0;
					acl_dir   <= 1'b0;
					rd_done   <= 1'b0;
					wr_done   <= 1'b0;
				end
				else
				begin
					if (go)
					begin
						acl_index <= dat_i[ACL_IDX_W-1:0];
						acl_dir   <= dat_i[ACL_DIR_BIT];
					end
					rd_done <= rd_fin | (rd_done & ~go); // [RQ10]
					wr_done <= wr_fin | (wr_done & ~go); // [RQ13]
				end
			end

			// Byte enable registers
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					bsel_hi <= BYTE_RST;
					bsel_lo <= BYTE_RST;
				end
				else
				begin
					if (sel_port && sub == ACL_BSEL_HI_OFS)
						bsel_hi <= dat_i[7:0]; // [RQ6]
					if (sel_port && sub == ACL_BSEL_LO_OFS)
						bsel_lo <= dat_i[7:0]; // [RQ6]
				end
			end

			// Staging bytes: table load wins over a bus write
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					for (int k = 0; k < ACL_BYTES; k++)
						stage[k] <= BYTE_RST;
				end
				else
				begin
					for (int k = 0; k < ACL_BYTES; k++)
					begin
						if (rd_fin)
							stage[k] <= table_q[8*k +: 8] & byte_mask(k); // [RQ11]
						else if (sel_port && sub == 8'(k))
							stage[k] <= dat_i[7:0] & byte_mask(k); // [RQ14] [RQ15] [RQ16] [RQ17]
					end
				end
			end

			// Readback of this port's window
			wire [7:0] ctrl_rd = {1'b0, wr_done, rd_done, acl_dir, acl_index};
			assign acl_rd[p] = (sub < 8'(ACL_BYTES)) ? stage[sub[3:0]] :
				(sub == ACL_BSEL_HI_OFS) ? bsel_hi :
				(sub == ACL_BSEL_LO_OFS) ? bsel_lo :
				(sub == ACL_CTRL_OFS)    ? ctrl_rd : BYTE_RST;
		end
	endgenerate

	// VLAN table and its access registers
	logic [VLAN_WORDS*VLAN_WORD_W-1:0] vlan_mem [VLAN_ENTRIES];
	logic [VLAN_WORDS*VLAN_WORD_W-1:0] vlan_q;
	logic [VLAN_WORD_W-1:0]            vlan_entry [VLAN_WORDS];
	logic [VLAN_IDX_W-1:0]             vlan_index;
	logic                              vlan_read_op;
	logic                              vlan_start;
	vlan_state_e                       vlan_state;
	vlan_state_e                       next_vlan_state;

	// VLAN register decode
	wire vlan_sel_idx  = wr_take & glob_hit & (reg_idx == VLAN_INDEX_REG);
	wire vlan_sel_ctrl = wr_take & glob_hit & (reg_idx == VLAN_CTRL_REG);
	wire vlan_go       = vlan_sel_ctrl & dat_i[VLAN_START_BIT]
		& (vlan_state == VLAN_IDLE); // [RQ2]
	wire [VLAN_WORDS*VLAN_WORD_W-1:0] vlan_wr_word =
		{vlan_entry[2], vlan_entry[1], vlan_entry[0]};

	// VLAN sequencer: look, load, or store, then drop start
	always_comb
	begin
		next_vlan_state = vlan_state;
		case (vlan_state)
			VLAN_IDLE:
				if (vlan_go)
					next_vlan_state = dat_i[VLAN_READ_BIT] ? VLAN_LOOK : VLAN_STORE;
			VLAN_LOOK:  next_vlan_state = VLAN_LOAD;
			VLAN_LOAD:  next_vlan_state = VLAN_IDLE;
			VLAN_STORE: next_vlan_state = VLAN_IDLE;
			default:    next_vlan_state = VLAN_IDLE;
		endcase
	end

	// Sequencer state, command and index registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			vlan_state   <= VLAN_IDLE;
			vlan_index   <= '0;
			vlan_read_op <= 1'b0;
			vlan_start   <= 1'b0;
		end
		else
		begin
			vlan_state <= next_vlan_state;
			if (vlan_sel_idx && vlan_state == VLAN_IDLE)
				vlan_index <= dat_i[VLAN_IDX_W-1:0]; // [RQ1] [RQ18]
			if (vlan_go)
			begin
				vlan_read_op <= dat_i[VLAN_READ_BIT];
				vlan_start   <= 1'b1; // [RQ2]
			end
			else if (vlan_state == VLAN_LOAD || vlan_state == VLAN_STORE)
				vlan_start <= 1'b0; // [RQ2]
		end
	end

	// Table array: registered read, write in the store step
	always_ff @(posedge clk_i)
	begin
		vlan_q <= vlan_mem[vlan_index]; // [RQ18]
		if (vlan_state == VLAN_STORE)
			vlan_mem[vlan_index] <= vlan_wr_word;
	end

	// Entry registers: loaded by a read, written by software otherwise
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int w = 0; w < VLAN_WORDS; w++)
				vlan_entry[w] <= WORD_RST;
		end
		else
		begin
			for (int w = 0; w < VLAN_WORDS; w++)
			begin
				if (vlan_state == VLAN_LOAD)
					vlan_entry[w] <= vlan_q[VLAN_WORD_W*w +: VLAN_WORD_W]; // [RQ3]
				else if (wr_take && glob_hit && vlan_state == VLAN_IDLE
					&& reg_idx == VLAN_ENTRY0_REG + 16'(w))
					vlan_entry[w] <= dat_i;
			end
		end
	end

	// Read data selection
	wire [7:0]  vlan_ctrl_rd = {vlan_start, 6'h00, vlan_read_op};
	wire [15:0] entry_off    = reg_idx - VLAN_ENTRY0_REG;
	wire        entry_hit    = glob_hit & (reg_idx >= VLAN_ENTRY0_REG)
		& (entry_off < 16'(VLAN_WORDS));
	wire [31:0] rd_value =
		acl_hit ? {24'h000000, acl_rd[hit_port]} :
		(glob_hit && reg_idx == VLAN_INDEX_REG) ? {20'h00000, vlan_index} :
		(glob_hit && reg_idx == VLAN_CTRL_REG)  ? {24'h000000, vlan_ctrl_rd} :
		entry_hit ? vlan_entry[entry_off[1:0]] : WORD_RST;

	// Read data flop, captured as ack rises
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_o <= WORD_RST;
		else if (req && !ack_q)
			dat_o <= rd_value;
	end

endmodule : acl_vlan_table_indirect_access

//--- verification/acl_vlan_props.sv
// Bus and register layout checks for the ACL and VLAN access block
`timescale 1ns/1ns
module acl_vlan_props
	import acl_vlan_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [31:0] dat_o,
	input  wire logic        ack_o
);
	// Request decode
	wire        req = cyc_i && stb_i && !ack_o;
	wire        rd  = req && !we_i;
	wire [15:0] idx = adr_i[17:2];
	wire        hit = adr_i[31:18] == 14'h0;
	wire        win = hit && idx[15:12] != 4'h0 && idx[15:12] <= NUM_PORTS && idx[11:8] == ACL_WIN_PAGE;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_on_time: assert property (req |=> ack_o) else $error("ack not one cycle after request");
	a_no_stray_ack: assert property (!req |=> !ack_o) else $error("ack without request");
	a_data_hold: assert property (!req |=> $stable(dat_o)) else $error("read data moved");
	a_reset_idle: assert property (disable iff (1'b0) rst_i |=> !ack_o && dat_o == 32'h0)
		else $error("bus not idle in reset");
	a_unmapped_zero: assert property (rd && !hit |=> dat_o == 32'h0) else $error("unmapped read");
	a_byte_c_zero: assert property (rd && win && idx[7:0] == 8'h0c |=> dat_o == 32'h0)
		else $error("unused byte not zero");
	a_cmd_layout: assert property (rd && win && idx[7:0] == ACL_CTRL_OFS |=> dat_o[31:7] == 25'h0)
		else $error("command upper bits set");
	a_rule_number: assert property (rd && win && idx[7:0] == 8'h00 |=> dat_o[31:4] == 28'h0)
		else $error("reserved bits of byte 0 set");
	a_vlan_index_w: assert property (rd && hit && idx == VLAN_INDEX_REG |=> dat_o[31:12] == 20'h0)
		else $error("vlan index wider than 12 bits");

	// Main scenarios
	cover property (rd && win && idx[7:0] == ACL_CTRL_OFS ##1 dat_o[ACL_RD_DONE_BIT]);
	cover property (req && we_i && win && idx[7:0] == ACL_CTRL_OFS && dat_i[ACL_DIR_BIT]);
	cover property (req && we_i && idx == VLAN_CTRL_REG && dat_i[VLAN_START_BIT]);
endmodule : acl_vlan_props

bind acl_vlan_table_indirect_access acl_vlan_props u_acl_vlan_props (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
	.dat_o(dat_o), .ack_o(ack_o));

//--- verification/testbench.sv
// Register-level sequences for the ACL and VLAN access block
`timescale 1ns/1ns
module testbench
	import acl_vlan_pkg::*;
;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic        ack;
	logic [3:0]  sel;
	logic [31:0] adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic [31:0] q;
	int          n_fail;
	int          checks;
	logic [7:0]  msk [16] = '{8'h0f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
		8'hff, 8'hff, 8'hff, 8'he0, 8'h00, 8'h7f, 8'hff, 8'hff};

	acl_vlan_table_indirect_access u_acl_vlan_table_indirect_access (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack));
	wb_host u_wb_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .sel_o(sel), .dat_o(wdat));

	// 125 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// Compare and count
	task automatic check(input string s, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", s, exp, got);
		end
	endtask : check

	task automatic test_done(input bit hung);
		if (hung)
			n_fail++;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	// Window index and staging pattern helpers
	function automatic logic [15:0] ai(int p, int k);
		return {p[3:0], ACL_WIN_PAGE, k[7:0]};
	endfunction : ai

	function automatic logic [31:0] pat(int k, logic [7:0] s);
		return {24'h0, ((8'(k) * 8'h11) ^ s) & msk[k]};
	endfunction : pat

	task automatic load(logic [7:0] s);
		for (int k = 0; k < 16; k++)
			u_wb_host.wr(ai(1, k), pat(k, s));
	endtask : load

	// Main sequence
	initial
	begin
		n_fail = 0;
		checks = 0;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset values, then field masks of port 1
		for (int k = 0; k < 19; k++)
		begin
			u_wb_host.rd(ai(1, k), q);
			check("reset", q, 32'h0);
		end
		for (int k = 0; k < 16; k++)
		begin
			u_wb_host.wr(ai(1, k), 32'hffff_ffff);
			u_wb_host.rd(ai(1, k), q);
			check("mask", q, {24'h0, msk[k]});
		end
		// Port windows apart, unmapped alias ignored
		u_wb_host.xfer(1'b1, 32'h0004_0000 | {14'h0, ai(2, 2), 2'b00}, 32'hff, q);
		u_wb_host.rd(ai(2, 2), q);
		check("port2", q, 32'h0);
		u_wb_host.xfer(1'b0, 32'h0004_0000 | {14'h0, ai(1, 2), 2'b00}, 32'h0, q);
		check("unmapped", q, 32'h0);
		// Entries 15 and 0 full, then 15 partial via reversed enables
		load(8'h00);
		u_wb_host.wr(ai(1, ACL_BSEL_HI_OFS), 32'hff);
		u_wb_host.wr(ai(1, ACL_BSEL_LO_OFS), 32'hff);
		u_wb_host.cmd(ai(1, ACL_CTRL_OFS), 8'h1f, ACL_WR_DONE_BIT, q);
		check("wr status", q, 32'h5f);
		load(8'h5a);
		u_wb_host.cmd(ai(1, ACL_CTRL_OFS), 8'h10, ACL_WR_DONE_BIT, q);
		check("wr status", q, 32'h50);
		load(8'ha5);
		u_wb_host.wr(ai(1, ACL_BSEL_HI_OFS), 32'h80);
		u_wb_host.wr(ai(1, ACL_BSEL_LO_OFS), 32'h09);
		u_wb_host.rd(ai(1, ACL_BSEL_HI_OFS), q);
		check("byte enable high", q, 32'h80);
		u_wb_host.rd(ai(1, ACL_BSEL_LO_OFS), q);
		check("byte enable low", q, 32'h09);
		u_wb_host.cmd(ai(1, ACL_CTRL_OFS), 8'h1f, ACL_WR_DONE_BIT, q);
		load(8'h33);
		u_wb_host.cmd(ai(1, ACL_CTRL_OFS), 8'h0f, ACL_RD_DONE_BIT, q);
		check("rd status", q, 32'h2f);
		for (int k = 0; k < 16; k++)
		begin
			u_wb_host.rd(ai(1, k), q);
			check("entry15", q, pat(k, (k == 0 || k == 15) ? 8'ha5 : 8'h00));
		end
		u_wb_host.cmd(ai(1, ACL_CTRL_OFS), 8'h00, ACL_RD_DONE_BIT, q);
		check("rd status", q, 32'h20);
		for (int k = 0; k < 16; k++)
		begin
			u_wb_host.rd(ai(1, k), q);
			check("entry0", q, pat(k, 8'h5a));
		end
		// VLAN entry 0xfff written, staging cleared, then read back
		for (int k = 0; k < 3; k++)
			u_wb_host.wr(VLAN_ENTRY0_REG + 16'(k), 32'ha5a5_0000 + k);
		u_wb_host.wr(VLAN_INDEX_REG, 32'hffff_ffff);
		u_wb_host.rd(VLAN_INDEX_REG, q);
		check("vlan index", q, 32'h0fff);
		u_wb_host.cmd(VLAN_CTRL_REG, 8'h80, VLAN_START_BIT, q);
		check("vlan ctrl write", q, 32'h00);
		for (int k = 0; k < 3; k++)
			u_wb_host.wr(VLAN_ENTRY0_REG + 16'(k), 32'h0);
		u_wb_host.cmd(VLAN_CTRL_REG, 8'h81, VLAN_START_BIT, q);
		check("vlan ctrl read", q, 32'h01);
		for (int k = 0; k < 3; k++)
		begin
			u_wb_host.rd(VLAN_ENTRY0_REG + 16'(k), q);
			check("vlan word", q, 32'ha5a5_0000 + k);
		end
		test_done(1'b0);
	end
endmodule : testbench

//--- verification/wb_host.sv
// Host software model driving the Wishbone register port
`timescale 1ns/1ns
module wb_host
	import acl_vlan_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [31:0]      adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o
);
	// Idle bus at time zero
	initial
	begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 32'h0;
		sel_o = 4'hf;
		dat_o = 32'h0;
	end

	// One classic cycle held until ack; released lines show inverse
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		dat_o <= d;
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_i !== 1'b1 && n < 64);
		if (ack_i !== 1'b1)
			testbench.test_done(1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		adr_o <= ~a;
		dat_o <= ~d;
	endtask : xfer

	// Register access by index
	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, {14'h0, i, 2'b00}, d, q);
	endtask : wr

	task automatic rd(input logic [15:0] i, output logic [31:0] q);
		xfer(1'b0, {14'h0, i, 2'b00}, 32'h0, q);
	endtask : rd

	// Start a table command, then poll its status bit
	task automatic cmd(input logic [15:0] i, input logic [7:0] d, input int b, output logic [31:0] q);
		int   n;
		logic want;
		want = (b == VLAN_START_BIT) ? 1'b0 : 1'b1;
		wr(i, {24'h0, d});
		n = 0;
		do
		begin
			rd(i, q);
			n++;
		end
		while (q[b] !== want && n < 8);
		if (q[b] !== want)
			testbench.test_done(1'b1);
	endtask : cmd
endmodule : wb_host
